// ==== logic/dtc_dual_timer.sv ====
// Dual 16-bit timer/counter with Avalon-MM register slave
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps

module dtc_dual_timer
   import dtc_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [7:0] avsAddress,
   input wire logic avsRead,
   input wire logic avsWrite,
   input wire logic [31:0] avsWriteData,
   input wire logic [3:0] avsByteEnable,
   output logic [31:0] avsReadData,
   output logic avsWaitRequest,
   input wire logic zeroCountPin,
   input wire logic oneCountPin,
   input wire logic zeroGatePin,
   input wire logic oneGatePin,
   input wire logic zeroIntAck,
   input wire logic oneIntAck,
   output logic zeroOverflowFlag,
   output logic oneOverflowFlag,
   output logic clockOutPin,
   output logic clockOutEnable
);

   // ==========================================================
   // Pin synchronisers and edge detection
   logic [3:0] pinMeta_r;
   logic [3:0] pinSync_r;
   logic [1:0] countPrev_r;
   logic [1:0] countFall;

   // Two flops on each count and gate pin
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pinMeta_r <= 4'h0;
         pinSync_r <= 4'h0;
         countPrev_r <= 2'h0;
      end else begin
         pinMeta_r <= {oneGatePin, zeroGatePin, oneCountPin, zeroCountPin};
         pinSync_r <= pinMeta_r;
         countPrev_r <= pinSync_r[1:0];
      end
   end

   assign countFall = countPrev_r & ~pinSync_r[1:0];

   // ==========================================================
   // Shared divide-by-twelve
   logic [3:0] divCnt_r;
   logic slowTick;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         divCnt_r <= 4'h0;
      end else if (divCnt_r == DTC_DIV_LAST) begin
         divCnt_r <= 4'h0;
      end else begin
         divCnt_r <= divCnt_r + 4'h1;
      end
   end
   assign slowTick = (divCnt_r == DTC_DIV_LAST);

   // ==========================================================
   // Registers
   logic [7:0] modeCfg_r;
   logic [7:0] auxCfg_r;
   logic zeroRun_r;
   logic oneRun_r;
   logic zeroFlag_r;
   logic oneFlag_r;
   logic [3:0] runCtlLow_r;
   logic [7:0] zeroLow_r;
   logic [7:0] zeroHigh_r;
   logic [7:0] oneLow_r;
   logic [7:0] oneHigh_r;

   // Bus decode, zero wait states
   logic wrEn;
   logic wrRunFlag;
   logic wrMode;
   logic wrAux;
   logic wrZeroLow;
   logic wrZeroHigh;
   logic wrOneLow;
   logic wrOneHigh;
   logic [7:0] wrByte;
   assign avsWaitRequest = 1'b0;
   assign wrEn = avsWrite & avsByteEnable[0];
   assign wrByte = avsWriteData[7:0];
   assign wrRunFlag = wrEn && (avsAddress == DTC_RUN_FLAG_OFF);
   assign wrMode = wrEn && (avsAddress == DTC_MODE_OFF);
   assign wrAux = wrEn && (avsAddress == DTC_AUX_OFF);
   assign wrZeroLow = wrEn && (avsAddress == DTC_ZERO_LOW_OFF);
   assign wrZeroHigh = wrEn && (avsAddress == DTC_ZERO_HIGH_OFF);
   assign wrOneLow = wrEn && (avsAddress == DTC_ONE_LOW_OFF);
   assign wrOneHigh = wrEn && (avsAddress == DTC_ONE_HIGH_OFF);

   // ==========================================================
   // Count enables per timer
   logic [1:0] zeroMode;
   logic [1:0] oneMode;
   logic zeroTick;
   logic oneTick;
   logic splitHighTick;
   logic zeroRunOk;
   logic oneRunOk;

   // Tick source: pin edge, fast clock or twelfth
   function automatic logic pick_tick(input logic isCounter,
                                      input logic fall,
                                      input logic fast,
                                      input logic slow);
      // counter counts pin, timer counts clock
      if (isCounter) begin
         return fall;
      end
      return fast ? 1'b1 : slow;
   endfunction

   // Gate qualification
   function automatic logic gate_ok(input logic run,
                                    input logic gate,
                                    input logic pin);
      return run & (~gate | pin);
   endfunction

   assign zeroMode = modeCfg_r[DTC_MODE_HI_BIT:DTC_MODE_LO_BIT];
   assign oneMode = modeCfg_r[DTC_MODE_HI_BIT + 4:DTC_MODE_LO_BIT + 4];
   // low nibble timer zero, high nibble one
   assign zeroRunOk = gate_ok(zeroRun_r, modeCfg_r[DTC_GATE_BIT],
                              pinSync_r[2]);
   assign oneRunOk = gate_ok(oneRun_r, modeCfg_r[DTC_GATE_BIT + 4],
                             pinSync_r[3]);
   assign zeroTick = zeroRunOk & pick_tick(modeCfg_r[DTC_CT_BIT],
      countFall[0], auxCfg_r[DTC_ZERO_FAST_BIT], slowTick);
   assign oneTick = oneRunOk & (oneMode != DTC_MODE_SPLIT) &
      pick_tick(modeCfg_r[DTC_CT_BIT + 4], countFall[1],
                auxCfg_r[DTC_ONE_FAST_BIT], slowTick);
   // high byte: timer only, timer one run
   assign splitHighTick = oneRun_r &
      (auxCfg_r[DTC_ZERO_FAST_BIT] | slowTick);

   // ==========================================================
   // Next-count arithmetic, shared by both timers
   typedef struct packed {
      logic [7:0] low;
      logic [7:0] high;
      logic ovf;
   } dtc_next_t;

   function automatic dtc_next_t step(input logic [1:0] mode,
                                      input logic [7:0] lo,
                                      input logic [7:0] hi);
      dtc_next_t r;
      r.low = lo;
      r.high = hi;
      r.ovf = 1'b0;
      unique case (mode)
         DTC_MODE_13: begin
            // five low bits prescale high byte
            r.low = {lo[7:5], lo[4:0] + 5'h01};
            if (lo[4:0] == DTC_PRESCALE_MAX) begin
               r.high = hi + 8'h01;
               r.ovf = (hi == 8'hFF);
            end
         end
         DTC_MODE_16: begin
            {r.high, r.low} = {hi, lo} + 16'h0001;
            r.ovf = ({hi, lo} == 16'hFFFF);
         end
         DTC_MODE_RELOAD: begin
            r.ovf = (lo == 8'hFF);
            r.low = r.ovf ? hi : lo + 8'h01;
         end
         DTC_MODE_SPLIT: begin
            r.low = lo + 8'h01;
            r.ovf = (lo == 8'hFF);
         end
      endcase
      return r;
   endfunction

   dtc_next_t zeroNext;
   dtc_next_t oneNext;
   logic [7:0] splitHighNext;
   logic zeroSplit;
   logic zeroOvf;
   logic oneOvf;
   // Next values for both timers
   assign zeroNext = step(zeroMode, zeroLow_r, zeroHigh_r);
   assign oneNext = step(oneMode, oneLow_r, oneHigh_r);
   assign zeroSplit = (zeroMode == DTC_MODE_SPLIT);
   assign splitHighNext = zeroHigh_r + 8'h01;
   assign zeroOvf = zeroTick & zeroNext.ovf;
   // split high byte overflow drives timer one flag
   assign oneOvf = zeroSplit ? (splitHighTick & (zeroHigh_r == 8'hFF))
                             : (oneTick & oneNext.ovf);

   // ==========================================================
   // Count registers; run bit never resets them
   // count written in the detection cycle
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         zeroLow_r <= DTC_RESET_BYTE;
         zeroHigh_r <= DTC_RESET_BYTE;
      end else begin
         if (wrZeroLow) begin
            zeroLow_r <= wrByte;
         end else if (zeroTick) begin
            zeroLow_r <= zeroNext.low;
         end
         if (wrZeroHigh) begin
            zeroHigh_r <= wrByte;
         end else if (zeroSplit) begin
            if (splitHighTick) begin
               zeroHigh_r <= splitHighNext;
            end
         end else if (zeroTick) begin
            zeroHigh_r <= zeroNext.high;
         end
      end
   end

   // Timer one count registers
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         oneLow_r <= DTC_RESET_BYTE;
         oneHigh_r <= DTC_RESET_BYTE;
      end else begin
         if (wrOneLow) begin
            oneLow_r <= wrByte;
         end else if (oneTick) begin
            oneLow_r <= oneNext.low;
         end
         if (wrOneHigh) begin
            oneHigh_r <= wrByte;
         end else if (oneTick) begin
            oneHigh_r <= oneNext.high;
         end
      end
   end

   // ==========================================================
   // Control, mode and aux registers
   // run bits written by software
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         modeCfg_r <= DTC_RESET_BYTE;
         auxCfg_r <= DTC_RESET_BYTE;
         zeroRun_r <= 1'b0;
         oneRun_r <= 1'b0;
         runCtlLow_r <= DTC_RESET_BYTE[3:0];
      end else begin
         if (wrMode) begin
            modeCfg_r <= wrByte;
         end
         if (wrAux) begin
            auxCfg_r <= wrByte;
         end
         if (wrRunFlag) begin
            zeroRun_r <= wrByte[DTC_ZERO_RUN_BIT];
            oneRun_r <= wrByte[DTC_ONE_RUN_BIT];
            runCtlLow_r <= wrByte[3:0];
         end
      end
   end

   // Overflow flags: set beats acknowledge and write
   // hardware set has priority
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         zeroFlag_r <= 1'b0;
         oneFlag_r <= 1'b0;
      end else begin
         if (zeroOvf) begin
            zeroFlag_r <= 1'b1;
         end else if (zeroIntAck) begin
            zeroFlag_r <= 1'b0;
         end else if (wrRunFlag) begin
            zeroFlag_r <= wrByte[DTC_ZERO_FLAG_BIT];
         end
         if (oneOvf) begin
            oneFlag_r <= 1'b1;
         end else if (oneIntAck) begin
            oneFlag_r <= 1'b0;
         end else if (wrRunFlag) begin
            oneFlag_r <= wrByte[DTC_ONE_FLAG_BIT];
         end
      end
   end
   assign zeroOverflowFlag = zeroFlag_r;
   assign oneOverflowFlag = oneFlag_r;

   // ==========================================================
   // Clock-out: toggle on each timer zero overflow
   logic clkOut_r;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         clkOut_r <= 1'b0;
      end else if (!auxCfg_r[DTC_CKOE_BIT]) begin
         clkOut_r <= 1'b0;
      end else if (zeroOvf) begin
         clkOut_r <= ~clkOut_r;
      end
   end
   assign clockOutPin = clkOut_r;
   assign clockOutEnable = auxCfg_r[DTC_CKOE_BIT];

   // ==========================================================
   // Read mux, live read data, registered copy held between reads
   logic [7:0] rdByte;
   logic [7:0] runFlagView;
   logic [31:0] rdData_r;
   // Run/flag byte as software sees it
   assign runFlagView = {oneFlag_r, oneRun_r, zeroFlag_r, zeroRun_r,
                         runCtlLow_r};
   // Unmapped addresses read as zero
   assign rdByte =
      (avsAddress == DTC_RUN_FLAG_OFF) ? runFlagView :
      (avsAddress == DTC_MODE_OFF) ? modeCfg_r :
      (avsAddress == DTC_AUX_OFF) ? auxCfg_r :
      (avsAddress == DTC_ZERO_LOW_OFF) ? zeroLow_r :
      (avsAddress == DTC_ZERO_HIGH_OFF) ? zeroHigh_r :
      (avsAddress == DTC_ONE_LOW_OFF) ? oneLow_r :
      (avsAddress == DTC_ONE_HIGH_OFF) ? oneHigh_r : DTC_RESET_BYTE;

   // Read data captured while read is high
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rdData_r <= 32'h0000_0000;
      end else if (avsRead) begin
         rdData_r <= {24'h00_0000, rdByte};
      end
   end
   // Live data during a read, last read data otherwise
   assign avsReadData = avsRead ? {24'h00_0000, rdByte} : rdData_r;
endmodule

// ==== logic/dtc_pkg.sv ====
// Package: register map, field positions and timing constants for the timers
package dtc_pkg;
   // ==========================================================
   // Register offsets (byte addresses on the bus)
   localparam logic [7:0] DTC_RUN_FLAG_OFF = 8'h88;
   localparam logic [7:0] DTC_MODE_OFF = 8'h89;
   localparam logic [7:0] DTC_AUX_OFF = 8'hA6;
   localparam logic [7:0] DTC_ZERO_LOW_OFF = 8'h90;
   localparam logic [7:0] DTC_ONE_LOW_OFF = 8'h94;
   localparam logic [7:0] DTC_ZERO_HIGH_OFF = 8'h98;
   localparam logic [7:0] DTC_ONE_HIGH_OFF = 8'h9C;
   // Unmapped address: writes ignored, reads zero
   localparam logic [7:0] DTC_SPARE_OFF = 8'hA4;
   // ==========================================================
   // Reset values
   localparam logic [7:0] DTC_RESET_BYTE = 8'h00;
   // ==========================================================
   // Field positions
   localparam int DTC_ONE_FLAG_BIT = 7;
   localparam int DTC_ONE_RUN_BIT = 6;
   localparam int DTC_ZERO_FLAG_BIT = 5;
   localparam int DTC_ZERO_RUN_BIT = 4;
   localparam int DTC_GATE_BIT = 3;
   localparam int DTC_CT_BIT = 2;
   localparam int DTC_MODE_HI_BIT = 1;
   localparam int DTC_MODE_LO_BIT = 0;
   localparam int DTC_ZERO_FAST_BIT = 7;
   localparam int DTC_ONE_FAST_BIT = 6;
   localparam int DTC_CKOE_BIT = 0;
   // ==========================================================
   // Modes and timing
   localparam logic [1:0] DTC_MODE_13 = 2'h0;
   localparam logic [1:0] DTC_MODE_16 = 2'h1;
   localparam logic [1:0] DTC_MODE_RELOAD = 2'h2;
   localparam logic [1:0] DTC_MODE_SPLIT = 2'h3;
   localparam int DTC_SLOW_DIV = 12;
   localparam logic [3:0] DTC_DIV_LAST = 4'(DTC_SLOW_DIV - 1);
   localparam logic [4:0] DTC_PRESCALE_MAX = 5'h1F;
endpackage

// ==== test/dtc_pin_model.sv ====
// Far-side model driving the count and gate pins
`timescale 1ns/1ps
module dtc_pin_model (
   input wire logic core_clk,
   input wire logic zeroGo,
   input wire logic oneGo,
   input wire logic zeroGateLvl,
   input wire logic oneGateLvl,
   output logic zeroCountPin,
   output logic oneCountPin,
   output logic zeroGatePin,
   output logic oneGatePin
);
   logic [7:0] zeroPhase_r = 8'h00;
   logic [7:0] onePhase_r = 8'h00;
   // Phase counters run only while a burst is asked for
   always @(posedge core_clk) begin
      zeroPhase_r <= zeroGo ? zeroPhase_r + 8'h01 : 8'h00;
      onePhase_r <= oneGo ? onePhase_r + 8'h01 : 8'h00;
   end
   assign zeroCountPin = ~zeroPhase_r[1];
   assign oneCountPin = ~onePhase_r[1];
   // Gate levels follow the bench command
   assign zeroGatePin = zeroGateLvl;
   assign oneGatePin = oneGateLvl;
endmodule

// ==== test/dtc_dual_timer_monitor.sv ====
// Port checker for the dual timer, with its bind
`timescale 1ns/1ps
module dtc_dual_timer_monitor
   import dtc_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [7:0] avsAddress,
   input wire logic avsRead,
   input wire logic avsWrite,
   input wire logic [31:0] avsWriteData,
   input wire logic [3:0] avsByteEnable,
   input wire logic [31:0] avsReadData,
   input wire logic zeroIntAck,
   input wire logic oneIntAck,
   input wire logic zeroOverflowFlag,
   input wire logic oneOverflowFlag,
   input wire logic clockOutPin,
   input wire logic clockOutEnable
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // Decoded bus accesses
   wire wrOk = avsWrite && avsByteEnable[0];
   wire wrRun = wrOk && avsAddress == DTC_RUN_FLAG_OFF;
   wire wrAux = wrOk && avsAddress == DTC_AUX_OFF;
   wire rdRun = avsRead && avsAddress == DTC_RUN_FLAG_OFF;
   wire wrMode = wrOk && avsAddress == DTC_MODE_OFF;
   wire rdMode = avsRead && avsAddress == DTC_MODE_OFF;
   // Write, idle cycle, then read of the same register
   sequence modeEcho_s;
      wrMode ##1 !avsWrite ##1 rdMode;
   endsequence
   sequence runEcho_s;
      wrRun ##1 !avsWrite ##1 rdRun;
   endsequence
   mode_echo_a: assert property (modeEcho_s |->
      avsReadData[7:0] == $past(avsWriteData[7:0], 2))
      else $error("mode register echo wrong");
   run_echo_a: assert property (runEcho_s |->
      avsReadData[6] == $past(avsWriteData[6], 2) &&
      avsReadData[4] == $past(avsWriteData[4], 2))
      else $error("run bits echo wrong");
   aux_enable_a: assert property (wrAux |=>
      clockOutEnable == $past(avsWriteData[DTC_CKOE_BIT]))
      else $error("clock-out enable not taken");
   cko_idle_a: assert property ((!clockOutEnable)[*3] |-> !clockOutPin)
      else $error("clock-out active while disabled");
   zero_hold_a: assert property (zeroOverflowFlag && !zeroIntAck &&
      !wrRun |=> zeroOverflowFlag)
      else $error("zero flag lost without acknowledge");
   one_hold_a: assert property (oneOverflowFlag && !oneIntAck &&
      !wrRun |=> oneOverflowFlag)
      else $error("one flag lost without acknowledge");
   zero_read_a: assert property (rdRun |->
      avsReadData[DTC_ZERO_FLAG_BIT] == zeroOverflowFlag)
      else $error("zero flag read differs");
   one_read_a: assert property (rdRun |->
      avsReadData[DTC_ONE_FLAG_BIT] == oneOverflowFlag)
      else $error("one flag read differs");
endmodule
bind dtc_dual_timer dtc_dual_timer_monitor dtc_dual_timer_monitor_inst (
   .core_clk(core_clk), .rst(rst), .avsAddress(avsAddress),
   .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
   .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
   .zeroIntAck(zeroIntAck), .oneIntAck(oneIntAck),
   .zeroOverflowFlag(zeroOverflowFlag), .oneOverflowFlag(oneOverflowFlag),
   .clockOutPin(clockOutPin), .clockOutEnable(clockOutEnable)
);

// ==== test/tb_top.sv ====
// Self-checking bench for the dual timer
`timescale 1ns/1ps
module tb_top
   import dtc_pkg::*;
;
   logic core_clk = 1'b0, rst = 1'b1, avsRead = 1'b0, avsWrite = 1'b0;
   logic zeroIntAck = 1'b0, oneIntAck = 1'b0, zeroGo = 1'b0, oneGo = 1'b0;
   logic zeroGateLvl = 1'b0, oneGateLvl = 1'b0;
   logic [7:0] avsAddress = 8'h00;
   logic [3:0] avsByteEnable = 4'h0;
   logic [31:0] avsWriteData = 32'h0000_0000, avsReadData;
   logic avsWaitRequest, zeroCountPin, oneCountPin, zeroGatePin, oneGatePin;
   logic zeroOverflowFlag, oneOverflowFlag, clockOutPin, clockOutEnable;
   int n_errors = 0, comparisons = 0, cycles = 0;
   // Clock, design and far-side model
   always #2 core_clk = ~core_clk;
   dtc_dual_timer dtc_dual_timer_inst (
      .core_clk(core_clk), .rst(rst), .avsAddress(avsAddress),
      .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
      .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
      .avsWaitRequest(avsWaitRequest), .zeroCountPin(zeroCountPin),
      .oneCountPin(oneCountPin), .zeroGatePin(zeroGatePin),
      .oneGatePin(oneGatePin), .zeroIntAck(zeroIntAck),
      .oneIntAck(oneIntAck), .zeroOverflowFlag(zeroOverflowFlag),
      .oneOverflowFlag(oneOverflowFlag), .clockOutPin(clockOutPin),
      .clockOutEnable(clockOutEnable));
   dtc_pin_model dtc_pin_model_inst (
      .core_clk(core_clk), .zeroGo(zeroGo), .oneGo(oneGo),
      .zeroGateLvl(zeroGateLvl), .oneGateLvl(oneGateLvl),
      .zeroCountPin(zeroCountPin), .oneCountPin(oneCountPin),
      .zeroGatePin(zeroGatePin), .oneGatePin(oneGatePin));
   task automatic chk(input logic [31:0] got, exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rng(input logic [7:0] v, lo, hi);
      chk(v >= lo && v <= hi, 1'b1);
   endtask
   task automatic wr(input logic [7:0] a, d);
      avsAddress <= a;
      avsWriteData <= {24'h00_0000, d};
      avsWrite <= 1'b1;
      do @(posedge core_clk); while (avsWaitRequest !== 1'b0);
      avsWrite <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      avsAddress <= a;
      avsRead <= 1'b1;
      do @(posedge core_clk); while (avsWaitRequest !== 1'b0);
      v = avsReadData[7:0];
      avsRead <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rc(input logic [7:0] a, e);
      logic [7:0] v;
      rd(a, v);
      chk(v, e);
   endtask
   task automatic ack(input logic z, o);
      zeroIntAck <= z;
      oneIntAck <= o;
      @(posedge core_clk);
      zeroIntAck <= 1'b0;
      oneIntAck <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic stop;
      logic [7:0] v;
      rd(DTC_RUN_FLAG_OFF, v);
      wr(DTC_RUN_FLAG_OFF, v & 8'hAF);
   endtask
   task automatic tmr(input logic [7:0] m, x, lo, hi, r, input int n);
      wr(DTC_MODE_OFF, m);
      wr(DTC_AUX_OFF, x);
      wr(DTC_ZERO_LOW_OFF, lo);
      wr(DTC_ZERO_HIGH_OFF, hi);
      wr(DTC_RUN_FLAG_OFF, r);
      repeat (n) @(posedge core_clk);
      stop;
   endtask
   task automatic pulse;
      zeroGo <= 1'b1;
      oneGo <= 1'b1;
      repeat (20) @(posedge core_clk);
      zeroGo <= 1'b0;
      oneGo <= 1'b0;
      repeat (8) @(posedge core_clk);
   endtask
   task automatic s_regs;
      rc(DTC_RUN_FLAG_OFF, 8'h00);
      rc(DTC_AUX_OFF, 8'h00);
      wr(DTC_MODE_OFF, 8'hA5);
      rc(DTC_MODE_OFF, 8'hA5);
      avsByteEnable <= 4'h0;
      wr(DTC_MODE_OFF, 8'h11);
      avsByteEnable <= 4'h1;
      rc(DTC_MODE_OFF, 8'hA5);
      wr(DTC_SPARE_OFF, 8'hFF);
      rc(DTC_SPARE_OFF, 8'h00);
      wr(DTC_AUX_OFF, 8'hC1);
      rc(DTC_AUX_OFF, 8'hC1);
   endtask
   task automatic s_fast;
      logic [7:0] v;
      tmr(8'h01, 8'h80, 8'hFE, 8'hFF, 8'h10, 20);
      chk(zeroOverflowFlag, 1'b1);
      rc(DTC_ZERO_HIGH_OFF, 8'h00);
      rd(DTC_ZERO_LOW_OFF, v);
      rng(v, 8'h0F, 8'h1F);
      ack(1'b1, 1'b0);
      chk(zeroOverflowFlag, 1'b0);
   endtask
   task automatic s_slow;
      logic [7:0] v;
      tmr(8'h01, 8'h00, 8'h00, 8'h00, 8'h10, 120);
      rd(DTC_ZERO_LOW_OFF, v);
      rng(v, 8'h09, 8'h0B);
   endtask
   task automatic s_reload;
      logic [7:0] v;
      tmr(8'h02, 8'h80, 8'hF8, 8'hF0, 8'h10, 30);
      rc(DTC_ZERO_HIGH_OFF, 8'hF0);
      rd(DTC_ZERO_LOW_OFF, v);
      rng(v, 8'hF0, 8'hFF);
      chk(zeroOverflowFlag, 1'b1);
      ack(1'b1, 1'b0);
   endtask
   task automatic s_wide13;
      logic [7:0] v;
      tmr(8'h00, 8'h80, 8'h1C, 8'hFF, 8'h10, 10);
      rc(DTC_ZERO_HIGH_OFF, 8'h00);
      rd(DTC_ZERO_LOW_OFF, v);
      rng(v, 8'h00, 8'h1F);
      chk(zeroOverflowFlag, 1'b1);
      ack(1'b1, 1'b0);
   endtask
   task automatic s_count;
      wr(DTC_ONE_LOW_OFF, 8'h00);
      tmr(8'hD5, 8'h00, 8'h00, 8'h00, 8'h00, 0);
      wr(DTC_RUN_FLAG_OFF, 8'h50);
      pulse;
      rc(DTC_ZERO_LOW_OFF, 8'h05);
      rc(DTC_ONE_LOW_OFF, 8'h00);
      oneGateLvl <= 1'b1;
      pulse;
      rc(DTC_ONE_LOW_OFF, 8'h05);
      rc(DTC_ZERO_LOW_OFF, 8'h0A);
      stop;
   endtask
   task automatic s_split;
      wr(DTC_ONE_LOW_OFF, 8'h10);
      tmr(8'h33, 8'h80, 8'h00, 8'hFE, 8'h40, 10);
      chk(oneOverflowFlag, 1'b1);
      chk(zeroOverflowFlag, 1'b0);
      rc(DTC_ZERO_LOW_OFF, 8'h00);
      rc(DTC_ONE_LOW_OFF, 8'h10);
      ack(1'b0, 1'b1);
      chk(oneOverflowFlag, 1'b0);
   endtask
   task automatic s_clkout;
      logic last;
      int t;
      int h;
      t = 0;
      h = 0;
      wr(DTC_MODE_OFF, 8'h02);
      wr(DTC_ZERO_LOW_OFF, 8'hFC);
      wr(DTC_ZERO_HIGH_OFF, 8'hFC);
      wr(DTC_AUX_OFF, 8'h81);
      wr(DTC_RUN_FLAG_OFF, 8'h10);
      last = clockOutPin;
      repeat (40) begin
         @(posedge core_clk);
         t += (clockOutPin != last);
         h += clockOutPin;
         last = clockOutPin;
      end
      rng(t[7:0], 8'h09, 8'h0B);
      rng(h[7:0], 8'h12, 8'h16);
      wr(DTC_AUX_OFF, 8'h80);
      repeat (3) @(posedge core_clk);
      chk(clockOutPin, 1'b0);
      stop;
   endtask
   // Flag-clearing write lands on the overflow edge
   task automatic s_race;
      wr(DTC_MODE_OFF, 8'h02);
      wr(DTC_AUX_OFF, 8'h80);
      wr(DTC_ZERO_LOW_OFF, 8'hFF);
      wr(DTC_ZERO_HIGH_OFF, 8'hFC);
      wr(DTC_RUN_FLAG_OFF, 8'h10);
      repeat (3) @(posedge core_clk);
      wr(DTC_RUN_FLAG_OFF, 8'h10);
      chk(zeroOverflowFlag, 1'b1);
      stop;
      ack(1'b1, 1'b0);
      chk(zeroOverflowFlag, 1'b0);
   endtask
   task automatic tally_and_finish;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Cycle ceiling against a hung handshake
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_errors++;
         tally_and_finish;
      end
   end
   // Reset, then the scenarios in turn
   initial begin
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      avsByteEnable <= 4'h1;
      @(posedge core_clk);
      s_regs;
      s_fast;
      s_slow;
      s_reload;
      s_wide13;
      s_count;
      s_split;
      s_clkout;
      s_race;
      tally_and_finish;
   end
endmodule
